// ==== metering_input_line_monitor.sv ====
// Summary of operation
// - current path gain is fixed x4 times PGA step 2/4/6/8: totals 8..32
// - select 0/1 Rogowski with added gain bit; 2 CT x8; 3 shunt x32
// - dual channel with select 3: primary CT x8, secondary shunt x32
// - dual channel: primary and secondary alternate on the one current path
// - voltage and current one-bit streams are taken in parallel
// - modulator clock is main clock over four, one bit per period
// - decimation gain 1.004 on voltage, 0.502 on current
// - voltage samples are 11 bits, current samples 16 bits
// - DC offset is tracked and removed from both channels
// - line frequency must lie between clock/2^17 and clock/2^15
// - marker at each positive peak; period counted between its trailing edges
// - too-long period or missing marker sets range error at once
// - too-short period sets range error only after three in a row
// - low RMS voltage sets range error; threshold depends on sensor and Kv
// - low-voltage cause clears only above twice the threshold
// - voltage calibrator is kept within 0.875 to 1.000
// - while in error, stepper and pulse outputs are held low
// - select below 2 uses Rogowski threshold, above 1 CT/shunt threshold
module metering_input_line_monitor
  import metering_pkg::*;
#(
  parameter int PERIOD_LOW_CYCLES = 2 ** PERIOD_LOW_LOG2,
  parameter int PERIOD_HIGH_CYCLES = 2 ** PERIOD_HIGH_LOG2,
  parameter int DEC_I_LEN = DEC_I_LEN_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic volt_bit_i,
  input wire logic curr_bit_i,
  output logic mod_clk_o,
  output logic curr_sec_sel_o,
  output logic [1:0] pga_gain_code_o,
  input wire drive_t drive_req_i,
  output logic stepper_drive_pos_o,
  output logic stepper_drive_neg_o,
  output logic energy_pulse_output_o,
  output logic line_frequency_range_error_o,
  output logic power_enable_o
);
  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic [1:0] div;
    logic mod_en;
    logic mod_clk;
    ctrl_t ctrl;
    logic [8:0] kv;
    logic chan_sec;
    logic [1:0] gain_code;
    logic [9:0] cnt_v;
    logic signed [11:0] acc_v;
    logic [15:0] cnt_i;
    logic signed [16:0] acc_i;
    logic signed [31:0] dc_v;
    logic signed [31:0] dc_i;
    logic signed [10:0] v_smp;
    logic v_new;
    logic i_done;
    logic i_chan;
    sample_t pend_smp;
    logic pend;
    logic overrun;
    peak_state_t pk;
    logic signed [10:0] v_prev;
    logic [17:0] per_cnt;
    logic [17:0] last_per;
    logic [1:0] hi_cnt;
    logic freq_low;
    logic freq_high;
    logic [7:0] rms_n;
    logic [29:0] sq_acc;
    logic rms_done;
    logic low_v;
    logic ack;
    logic [31:0] dat;
    drive_t drv;
  } st_t;
  st_t q, s;
  logic req, rd_pop, trail, err;
  logic fifo_ready, fifo_valid, fifo_full;
  sample_t fifo_head;
  logic signed [31:0] av, ai, xv, xi, vw;
  logic [29:0] sq;
  logic [21:0] ms;
  logic [39:0] lvl, thr2;
  logic [15:0] thr;
  logic [8:0] kw;

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic signed [31:0] scale_sat(input logic signed [31:0] x, input int num, input int sh,
                                                   input int w);
    logic signed [31:0] p;
    logic signed [31:0] lim;
    p = (x * num) >>> sh;
    lim = (32'sd1 <<< (w - 1)) - 32'sd1;
    if (p > lim) return lim;
    if (p < -lim - 32'sd1) return -lim - 32'sd1;
    return p;
  endfunction

  // leaky average with 8 fraction bits; slow enough to pass the line tone
  function automatic logic signed [31:0] dc_track(input logic signed [31:0] acc, input logic signed [31:0] x);
    return acc + (((x <<< 8) - acc) >>> DC_SHIFT);
  endfunction

  function automatic logic [1:0] gain_sel(input ctrl_t c, input logic sec);
    case (c.sensor_gain_select)
      2'h0, 2'h1: return {c.sensor_gain_select[0], c.added_gain_bit};
      2'h2: return PGA_X2;
      default: return (c.dual && !sec) ? PGA_X2 : PGA_X8;
    endcase
  endfunction

  // ******************************************************************
  // sample buffer
  // ******************************************************************
  sample_fifo #(
    .WIDTH($bits(sample_t)),
    .DEPTH(16)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_valid_i(q.pend),
    .wr_ready_o(fifo_ready),
    .wr_data_i(q.pend_smp),
    .rd_valid_o(fifo_valid),
    .rd_ready_i(rd_pop),
    .rd_data_o(fifo_head),
    .full_o(fifo_full)
  );

  assign req = wb_cyc_i && wb_stb_i;
  assign rd_pop = req && !q.ack && !wb_we_i && wb_adr_i == ADR_SAMPLE;
  assign err = q.freq_low || q.freq_high || q.low_v;

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    s = q;
    trail = 1'b0;
    av = '0;
    ai = '0;
    xv = '0;
    xi = '0;
    vw = '0;
    sq = '0;
    ms = '0;
    lvl = '0;
    thr = '0;
    thr2 = '0;
    kw = q.kv;
    s.v_new = 1'b0;
    s.i_done = 1'b0;
    s.rms_done = 1'b0;
    s.mod_en = 1'b0;
    if (q.ctrl.enable) begin
      s.div = q.div + 2'h1;
      s.mod_en = q.div == MOD_DIV_LAST;
    end
    s.mod_clk = q.div[1];
    // both streams advance on the same modulator tick
    if (q.mod_en) begin
      av = 32'(q.acc_v) + (volt_bit_i ? 32'sd1 : -32'sd1);
      ai = 32'(q.acc_i) + (curr_bit_i ? 32'sd1 : -32'sd1);
      s.acc_v = 12'(av);
      s.acc_i = 17'(ai);
      s.cnt_v = q.cnt_v + 10'h1;
      s.cnt_i = q.cnt_i + 16'h1;
      if (q.cnt_v == DEC_V_LAST) begin
        xv = scale_sat(av, GAIN_V_NUM, GAIN_V_SHIFT, 11);
        s.dc_v = dc_track(q.dc_v, xv);
        s.v_smp = 11'(scale_sat(xv - (q.dc_v >>> 8), 1, 0, 11));
        s.v_new = 1'b1;
        s.acc_v = '0;
        s.cnt_v = '0;
      end
      if (q.cnt_i == 16'(DEC_I_LEN - 1)) begin
        xi = scale_sat(ai, GAIN_I_NUM, GAIN_I_SHIFT, 16);
        s.dc_i = dc_track(q.dc_i, xi);
        s.pend_smp.current = 16'(scale_sat(xi - (q.dc_i >>> 8), 1, 0, 16));
        s.i_chan = q.chan_sec;
        s.chan_sec = q.ctrl.dual && !q.chan_sec;
        s.i_done = 1'b1;
        s.acc_i = '0;
        s.cnt_i = '0;
      end
    end
    // a voltage sample carries the latest current sample into the buffer
    if (q.pend && fifo_ready) s.pend = 1'b0;
    if (q.v_new) begin
      if (q.pend && !fifo_ready) s.overrun = 1'b1;
      s.pend = 1'b1;
      s.pend_smp.voltage = q.v_smp;
    end
    // positive peak marker
    if (q.v_new) begin
      s.v_prev = q.v_smp;
      case (q.pk)
        PK_IDLE: if (q.v_smp > 11'sd0) s.pk = PK_RISE;
        PK_RISE: begin
          if (q.v_smp <= 11'sd0) s.pk = PK_IDLE;
          else if (q.v_smp < q.v_prev) s.pk = PK_MARK;
        end
        PK_MARK: begin
          if (q.v_smp <= 11'sd0) begin
            s.pk = PK_IDLE;
            trail = 1'b1;
          end
        end
        default: s.pk = PK_IDLE;
      endcase
    end
    // period monitor
    if (q.ctrl.enable) begin
      if (trail) begin
        s.last_per = q.per_cnt;
        s.per_cnt = 18'h1;
        s.freq_low = q.per_cnt > 18'(PERIOD_LOW_CYCLES);
        if (q.per_cnt < 18'(PERIOD_HIGH_CYCLES)) begin
          s.hi_cnt = (q.hi_cnt == HIGH_REPEAT) ? HIGH_REPEAT : q.hi_cnt + 2'h1;
        end else begin
          s.hi_cnt = 2'h0;
        end
      end else begin
        if (q.per_cnt <= 18'(PERIOD_LOW_CYCLES)) s.per_cnt = q.per_cnt + 18'h1;
        if (q.per_cnt > 18'(PERIOD_LOW_CYCLES)) s.freq_low = 1'b1;
      end
    end
    s.freq_high = s.hi_cnt == HIGH_REPEAT;
    // mean square over 256 voltage samples, compared as squares to skip a root
    if (q.v_new) begin
      vw = 32'(q.v_smp);
      sq = q.sq_acc + 30'(vw * vw);
      s.sq_acc = sq;
      s.rms_n = q.rms_n + 8'h1;
      if (q.rms_n == RMS_LAST) begin
        ms = sq[29:8];
        lvl = 40'(ms) * 40'(q.kv) * 40'(q.kv);
        thr = q.ctrl.sensor_gain_select < 2'h2 ? LV_THR_ROG : LV_THR_CT;
        thr2 = 40'(thr) * 40'(thr);
        if (lvl < thr2) s.low_v = 1'b1;
        else if (lvl > (thr2 << 2)) s.low_v = 1'b0;
        s.rms_done = 1'b1;
        s.sq_acc = '0;
      end
    end
    // held low while any cause of the range error stands
    s.drv.pos = drive_req_i.pos && !err && q.ctrl.enable;
    s.drv.neg = drive_req_i.neg && !err && q.ctrl.enable;
    s.drv.pulse = drive_req_i.pulse && !err && q.ctrl.enable;
    // wishbone slave: ack one cycle after the request, write at the ack edge
    s.ack = req && !q.ack;
    if (req && !q.ack && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: s.dat = {27'h0, q.ctrl};
        ADR_KV: s.dat = {23'h0, q.kv};
        ADR_STATUS: begin
          s.dat = {23'h0, fifo_full, q.overrun, fifo_valid, q.i_chan, q.low_v, q.freq_high, q.freq_low,
                   err, q.pk == PK_MARK};
          if (!(q.v_new && q.pend && !fifo_ready)) s.overrun = 1'b0;
        end
        ADR_PERIOD: s.dat = {14'h0, q.last_per};
        ADR_SAMPLE: s.dat = fifo_valid ? {5'h0, fifo_head} : 32'h0;
        default: s.dat = 32'h0;
      endcase
    end
    if (req && q.ack && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: if (wb_sel_i[0]) s.ctrl = ctrl_t'(wb_dat_i[4:0]);
        ADR_KV: begin
          if (wb_sel_i[0]) kw[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) kw[8] = wb_dat_i[8];
          s.kv = kw < KV_MIN ? KV_MIN : (kw > KV_MAX ? KV_MAX : kw);
        end
        default: ;
      endcase
    end
    // from next values, so gain code and channel select switch in the same cycle
    s.gain_code = gain_sel(s.ctrl, s.chan_sec);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= ctrl_t'(CTRL_RESET);
      q.kv <= KV_RESET;
    end else begin
      q <= s;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign mod_clk_o = q.mod_clk;
  assign curr_sec_sel_o = q.chan_sec;
  assign pga_gain_code_o = q.gain_code;
  assign stepper_drive_pos_o = q.drv.pos;
  assign stepper_drive_neg_o = q.drv.neg;
  assign energy_pulse_output_o = q.drv.pulse;
  assign line_frequency_range_error_o = err;
  assign power_enable_o = !err && q.ctrl.enable;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_mod_tick;
    q.mod_en && q.ctrl.enable |=> !q.mod_en [* 3] ##1 (q.mod_en || !q.ctrl.enable);
  endproperty
  a_mod_tick: assert property (p_mod_tick) else $error("modulator tick not every fourth cycle");

  property p_gain_rog;
    q.ctrl.sensor_gain_select < 2'h2 |-> q.gain_code == {q.ctrl.sensor_gain_select[0],
                                                        q.ctrl.added_gain_bit};
  endproperty
  a_gain_rog: assert property (p_gain_rog) else $error("coil gain code wrong");

  property p_gain_fixed;
    q.ctrl.sensor_gain_select == 2'h3 && !(q.ctrl.dual && !q.chan_sec) |-> q.gain_code == PGA_X8;
  endproperty
  a_gain_fixed: assert property (p_gain_fixed) else $error("shunt gain not x32");

  property p_chan_alt;
    q.mod_en && q.cnt_i == 16'(DEC_I_LEN - 1) && q.ctrl.dual |=> q.chan_sec != $past(q.chan_sec);
  endproperty
  a_chan_alt: assert property (p_chan_alt) else $error("current channel did not alternate");

  property p_low_freq;
    q.ctrl.enable && q.per_cnt > 18'(PERIOD_LOW_CYCLES) |=> q.freq_low && err;
  endproperty
  a_low_freq: assert property (p_low_freq) else $error("long period did not raise error");

  property p_high_early;
    trail && q.hi_cnt == 2'h0 |=> !q.freq_high;
  endproperty
  a_high_early: assert property (p_high_early) else $error("high frequency flagged too early");

  property p_high_third;
    q.ctrl.enable && trail && q.hi_cnt == 2'h2 && q.per_cnt < 18'(PERIOD_HIGH_CYCLES) |=> q.freq_high;
  endproperty
  a_high_third: assert property (p_high_third) else $error("third short period not flagged");

  property p_drive_off;
    err |=> !stepper_drive_pos_o && !stepper_drive_neg_o && !energy_pulse_output_o;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive active during range error");

  property p_lowv_cause;
    $changed(q.low_v) |-> $past(q.v_new) && $past(q.rms_n) == RMS_LAST;
  endproperty
  a_lowv_cause: assert property (p_lowv_cause) else $error("low voltage changed off window");

  property p_kv_range;
    q.kv >= KV_MIN && q.kv <= KV_MAX;
  endproperty
  a_kv_range: assert property (p_kv_range) else $error("calibrator out of range");

  c_trail: cover property (trail);
  c_high: cover property ($rose(q.freq_high));
  c_lowv: cover property ($rose(q.low_v));
  c_full: cover property (fifo_full);
endmodule

// ==== metering_pkg.sv ====
package metering_pkg;
  // ******************************************************************
  // register map and reset values
  // ******************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_KV = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_PERIOD = 8'h0c;
  localparam logic [7:0] ADR_SAMPLE = 8'h10;
  localparam logic [4:0] CTRL_RESET = 5'h10;
  localparam logic [8:0] KV_RESET = 9'h100;
  localparam logic [8:0] KV_MIN = 9'h0e0;
  localparam logic [8:0] KV_MAX = 9'h100;
  // ******************************************************************
  // timing, decimation and thresholds
  // ******************************************************************
  localparam logic [1:0] MOD_DIV_LAST = 2'h3;
  localparam int PERIOD_LOW_LOG2 = 17;
  localparam int PERIOD_HIGH_LOG2 = 15;
  localparam logic [1:0] HIGH_REPEAT = 2'h3;
  localparam logic [9:0] DEC_V_LAST = 10'h3ff;
  localparam int DEC_I_LEN_DEF = 32768;
  localparam int GAIN_V_NUM = 257;
  localparam int GAIN_V_SHIFT = 8;
  localparam int GAIN_I_NUM = 257;
  localparam int GAIN_I_SHIFT = 9;
  localparam int DC_SHIFT = 6;
  localparam logic [7:0] RMS_LAST = 8'hff;
  localparam longint V_FULL_CODE = 1024;
  localparam longint V_FULL_MV = 300;
  localparam longint KV_ONE = 256;
  localparam logic [15:0] LV_THR_CT = 16'((64'd64 * V_FULL_CODE * KV_ONE * 1000) / (64'd6703 * V_FULL_MV));
  localparam logic [15:0] LV_THR_ROG = 16'((64'd64 * V_FULL_CODE * KV_ONE * 1000) / (64'd6687 * V_FULL_MV));
  localparam logic [1:0] PGA_X2 = 2'h0;
  localparam logic [1:0] PGA_X8 = 2'h3;
  // ******************************************************************
  // types
  // ******************************************************************
  typedef struct packed {
    logic enable;
    logic dual;
    logic added_gain_bit;
    logic [1:0] sensor_gain_select;
  } ctrl_t;
  typedef struct packed {
    logic signed [15:0] current;
    logic signed [10:0] voltage;
  } sample_t;
  typedef struct packed {
    logic pos;
    logic neg;
    logic pulse;
  } drive_t;
  typedef enum logic [1:0] {PK_IDLE = 2'b00, PK_RISE = 2'b01, PK_MARK = 2'b10} peak_state_t;
endpackage

// ==== sample_fifo.sv ====
module sample_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t q, s;
  logic [WIDTH-1:0] mem [DEPTH];
  assign full_o = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign wr_ready_o = !full_o;
  assign rd_valid_o = q.wp != q.rp;
  assign rd_data_o = mem[q.rp[AW-1:0]];
  always_comb begin
    s = q;
    if (wr_valid_i && wr_ready_o) s.wp = q.wp + 1'b1;
    if (rd_valid_o && rd_ready_i) s.rp = q.rp + 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) q <= '0;
    else q <= s;
    if (wr_valid_i && wr_ready_o) mem[q.wp[AW-1:0]] <= wr_data_i;
  end
endmodule

// ==== sd_stream_model.sv ====
module sd_stream_model #(
  parameter int V_LEVEL = 100,
  parameter int I_LEVEL = -200
) (
  input wire logic clk_i,
  input wire logic mod_clk_i,
  output logic volt_bit_o,
  output logic curr_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // first-order modulators, full scale 1024
  // ****************************************
  int v_acc = 0;
  int i_acc = 0;
  logic mod_clk_d = 1'b0;
  initial begin
    volt_bit_o = 1'b0;
    curr_bit_o = 1'b0;
  end
  // new bit on the falling modulator edge so it is steady when sampled
  always @(posedge clk_i) begin
    mod_clk_d <= mod_clk_i;
    if (mod_clk_d && !mod_clk_i) begin
      volt_bit_o <= (v_acc >= 0);
      curr_bit_o <= (i_acc >= 0);
      v_acc <= v_acc + V_LEVEL - ((v_acc >= 0) ? 1024 : -1024);
      i_acc <= i_acc + I_LEVEL - ((i_acc >= 0) ? 1024 : -1024);
    end
  end
endmodule

// ==== tb_metering_input_line_monitor.sv ====
module tb_metering_input_line_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import metering_pkg::*;
  // ****************************************
  // stimulus and design
  // ****************************************
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [2:0] g;
  } row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic volt_bit_i;
  logic curr_bit_i;
  logic mod_clk_o;
  logic curr_sec_sel_o;
  logic [1:0] pga_gain_code_o;
  drive_t drive_req_i = '0;
  logic stepper_drive_pos_o;
  logic stepper_drive_neg_o;
  logic energy_pulse_output_o;
  logic line_frequency_range_error_o;
  logic power_enable_o;
  int n_fail = 0;
  int cmp_count = 0;
  int k;
  int t0;
  int cyc_cnt = 0;
  logic m;
  logic [31:0] rd;
  row_t rows[13];

  metering_input_line_monitor #(
    .PERIOD_LOW_CYCLES(2048),
    .PERIOD_HIGH_CYCLES(512),
    .DEC_I_LEN(64)
  ) metering_input_line_monitor_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .volt_bit_i, .curr_bit_i, .mod_clk_o, .curr_sec_sel_o, .pga_gain_code_o, .drive_req_i,
    .stepper_drive_pos_o, .stepper_drive_neg_o, .energy_pulse_output_o, .line_frequency_range_error_o,
    .power_enable_o
  );
  sd_stream_model sd_stream_model_inst (
    .clk_i(clk_i),
    .mod_clk_i(mod_clk_o),
    .volt_bit_o(volt_bit_i),
    .curr_bit_o(curr_bit_i)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic cycle; waits for ack, bench timeout is the only limit
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic results();
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cyc_cnt + 1;
  endtask

  // fill of 16 voltage samples dominates the run time
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    results();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rows = '{'{ADR_CTRL, 32'h10, 32'h10, 3'h4}, '{ADR_CTRL, 32'h14, 32'h14, 3'h5},
             '{ADR_CTRL, 32'h11, 32'h11, 3'h6}, '{ADR_CTRL, 32'h15, 32'h15, 3'h7},
             '{ADR_CTRL, 32'h12, 32'h12, 3'h4}, '{ADR_CTRL, 32'h16, 32'h16, 3'h4},
             '{ADR_CTRL, 32'h13, 32'h13, 3'h7}, '{ADR_CTRL, 32'h17, 32'h17, 3'h7},
             '{ADR_KV, 32'h0, 32'he0, 3'h0}, '{ADR_KV, 32'h1ff, 32'h100, 3'h0},
             '{ADR_KV, 32'hf0, 32'hf0, 3'h0}, '{8'h20, 32'hffffffff, 32'h0, 3'h0},
             '{ADR_CTRL, 32'h10, 32'h10, 3'h4}};
    do_reset();
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd, rd);
      wb(1'b0, rows[i].adr, 32'h0, rd);
      chk(rd, rows[i].rd);
      if (rows[i].g[2]) chk(32'(pga_gain_code_o), 32'(rows[i].g[1:0]));
    end
    // mid-run reset restores defaults and restarts the period count
    do_reset();
    wb(1'b0, ADR_CTRL, 32'h0, rd);
    chk(rd, 32'(CTRL_RESET));
    wb(1'b0, ADR_KV, 32'h0, rd);
    chk(rd, 32'(KV_RESET));
    drive_req_i <= 3'b111;
    repeat (2) @(posedge clk_i);
    #1;
    chk({stepper_drive_pos_o, stepper_drive_neg_o, energy_pulse_output_o, power_enable_o}, 4'hf);
    k = 0;
    m = mod_clk_o;
    repeat (400) begin
      @(posedge clk_i);
      #1;
      if (mod_clk_o && !m) k++;
      m = mod_clk_o;
    end
    chk(k >= 99 && k <= 101, 1);
    wb(1'b1, ADR_CTRL, 32'h1b, rd);
    k = 0;
    repeat (12) begin
      repeat (50) @(posedge clk_i);
      #1;
      chk(32'(pga_gain_code_o), curr_sec_sel_o ? 32'h3 : 32'h0);
      k += curr_sec_sel_o;
    end
    chk(k > 0 && k < 12, 1);
    wb(1'b1, ADR_CTRL, 32'h10, rd);
    // no marker trailing edge ever comes: a stalled count must flag the range
    while (line_frequency_range_error_o !== 1'b1 && cyc_cnt - t0 < 8192) @(posedge clk_i);
    chk((cyc_cnt - t0) >= 2049 && (cyc_cnt - t0) <= 2200, 1);
    repeat (2) @(posedge clk_i);
    #1;
    chk({stepper_drive_pos_o, stepper_drive_neg_o, energy_pulse_output_o, power_enable_o}, 4'h0);
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    chk(rd[3:1], 3'b011);
    k = 0;
    do begin
      repeat (512) @(posedge clk_i);
      wb(1'b0, ADR_STATUS, 32'h0, rd);
      k++;
    end while (!rd[8] && k < 160);
    // the held slot takes the seventeenth sample; overrun needs the eighteenth
    repeat (8400) @(posedge clk_i);
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    chk(rd[8:7], 2'b11);
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    chk(rd[7], 1'b0);
    // sixteen buffered samples plus the held one; first voltage has no offset removed yet
    for (k = 0; k < 17; k++) begin
      wb(1'b0, ADR_SAMPLE, 32'h0, rd);
      if (k == 0) chk($signed(rd[10:0]) >= 11'sd96 && $signed(rd[10:0]) <= 11'sd104, 1'b1);
      if (k == 0) chk($signed(rd[26:11]) >= -16'sd9 && $signed(rd[26:11]) <= -16'sd3, 1'b1);
      if (k == 16) chk($signed(rd[10:0]) >= 11'sd70 && $signed(rd[10:0]) <= 11'sd84, 1'b1);
    end
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    chk({rd[8], rd[6]}, 2'b00);
    wb(1'b0, ADR_SAMPLE, 32'h0, rd);
    chk(rd, 32'h0);
    results();
  end
endmodule
